// file: hw/upm_pkg.sv
// Constants and types for the uptime counter and program I/O map tables
// Behaviour
// RULE1: Read-only 32-bit seconds counter, readable and mappable
// RULE2: Counter restarts from zero at every switch-on
// RULE3: Before run, copy input-table objects into image
// RULE4: After run, copy image results to output-table objects
// RULE5: Sixteen entries; subindex zero reads 10h
// RULE6: Entry: index 31..16, subindex 15..8, length 7..0
// RULE7: Length field counts bits, not bytes
// RULE8: Index picks object, subindex picks its element
// RULE9: Entries read-only to master, reset to zero
// RULE10: Prescaled one-second steps, wraps past maximum
// RULE11: All-zero entry is unused and skipped
package upm_pkg;

    // =========================================================
    // Object dictionary indices
    localparam logic [15:0] OD_IDX_UPTIME = 16'h230f;
    localparam logic [15:0] OD_IDX_IN_MAP = 16'h2310;
    localparam logic [15:0] OD_IDX_OUT_MAP = 16'h2320;
    localparam logic [7:0] OD_SUB_COUNT = 8'h00;

    // =========================================================
    // Map tables and entry layout
    localparam int MAP_ENTRIES = 16;
    localparam logic [7:0] MAP_HIGHEST_SUB = 8'h10;
    localparam logic [3:0] MAP_LAST_SLOT = 4'hf;
    localparam int MAP_IDX_MSB = 31;
    localparam int MAP_IDX_LSB = 16;
    localparam int MAP_SUB_MSB = 15;
    localparam int MAP_SUB_LSB = 8;
    localparam int MAP_LEN_MSB = 7;
    localparam int MAP_LEN_LSB = 0;
    localparam logic [31:0] MAP_RESET = 32'h0000_0000;
    localparam logic [31:0] UPTIME_RESET = 32'h0000_0000;

    // =========================================================
    // Timing
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int UPTIME_STEP_S = 1;
    localparam int SECOND_CYCLES = UPTIME_STEP_S * CLK_FREQ_HZ;

    // =========================================================
    // Copy engine
    typedef enum logic [1:0] {
        COPY_IDLE,
        COPY_SCAN,
        COPY_WAIT
    } upm_copy_e;

endpackage

// file: hw/upm_uptime_ctr.sv
// Seconds-since-power-on counter with clock prescaler
`timescale 1ns/1ps
module upm_uptime_ctr
    import upm_pkg::*;
#(
    parameter int P_SECOND_CYCLES = SECOND_CYCLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    output logic [31:0] o_count
);

    localparam logic [31:0] LAST_CYCLE = 32'(P_SECOND_CYCLES - 1);

    logic [31:0] presc_q;
    logic [31:0] count_q;
    wire tick = (presc_q == LAST_CYCLE);

    // =========================================================
    // Prescaler and counter
    // No retention: power-on reset is the only start point
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            presc_q <= 32'h0000_0000;
            count_q <= UPTIME_RESET; // see RULE2
        end
        else
        begin
            presc_q <= tick ? 32'h0000_0000 : presc_q + 32'h0000_0001;
            // Natural 32-bit overflow gives the wrap
            if (tick)
                count_q <= count_q + 32'h0000_0001; // see RULE10
        end
    end

    assign o_count = count_q; // see RULE1

    // =========================================================
    // Checks
    property p_uptime_zero;
        @(posedge i_sys_clk) i_rst |=> (count_q == 32'h0000_0000);
    endproperty
    a_uptime_zero: assert property (p_uptime_zero) // see RULE2
        else $error("uptime not zero after reset");

    property p_uptime_step;
        @(posedge i_sys_clk) disable iff (i_rst)
        tick |=> (count_q == $past(count_q) + 32'h0000_0001);
    endproperty
    a_uptime_step: assert property (p_uptime_step) // see RULE10
        else $error("uptime did not step by one");

    property p_uptime_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !tick |=> $stable(count_q);
    endproperty
    a_uptime_hold: assert property (p_uptime_hold) // see RULE10
        else $error("uptime changed between seconds");

    property p_presc_bound;
        @(posedge i_sys_clk) disable iff (i_rst)
        presc_q <= LAST_CYCLE;
    endproperty
    a_presc_bound: assert property (p_presc_bound) // see RULE10
        else $error("prescaler ran past one second");

endmodule

// file: hw/upm_uptime_and_map.sv
// Uptime object, program input/output map tables and copy sequencer
`timescale 1ns/1ps
module upm_uptime_and_map
    import upm_pkg::*;
#(
    parameter int P_SECOND_CYCLES = SECOND_CYCLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_od_rd,
    input wire logic i_od_wr,
    input wire logic [15:0] i_od_index,
    input wire logic [7:0] i_od_subidx,
    output logic o_od_valid,
    output logic o_od_abort,
    output logic [31:0] o_od_rdata,
    input wire logic i_map_load,
    input wire logic i_map_load_out,
    input wire logic [3:0] i_map_load_slot,
    input wire logic [31:0] i_map_load_data,
    input wire logic i_pre_run_start,
    input wire logic i_post_run_start,
    output logic o_busy,
    output logic o_phase_done,
    output logic o_copy_req,
    input wire logic i_copy_ack,
    output logic o_copy_to_image,
    output logic [15:0] o_copy_index,
    output logic [7:0] o_copy_subidx,
    output logic [7:0] o_copy_len_bits,
    output logic [3:0] o_copy_slot,
    output logic [31:0] o_uptime_sec
);

    logic [31:0] in_map_q [MAP_ENTRIES];
    logic [31:0] out_map_q [MAP_ENTRIES];
    logic [31:0] uptime;

    upm_uptime_ctr #(
        .P_SECOND_CYCLES(P_SECOND_CYCLES)
    ) u_uptime (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .o_count(uptime)
    );

    assign o_uptime_sec = uptime; // see RULE1

    // =========================================================
    // Table storage
    // Loads are refused mid-sequence so a walk sees one table
    logic busy_q;
    wire load_ok = i_map_load & ~busy_q;

    generate
        for (genvar g = 0; g < MAP_ENTRIES; g++)
        begin : g_entry
            wire hit = load_ok & (i_map_load_slot == 4'(g));
            always_ff @(posedge i_sys_clk)
            begin
                if (i_rst)
                begin
                    in_map_q[g] <= MAP_RESET; // see RULE9
                    out_map_q[g] <= MAP_RESET; // see RULE9
                end
                else if (hit & ~i_map_load_out)
                    in_map_q[g] <= i_map_load_data;
                else if (hit & i_map_load_out)
                    out_map_q[g] <= i_map_load_data;
            end
        end
    endgenerate

    // =========================================================
    // Object dictionary decode
    wire hit_up = (i_od_index == OD_IDX_UPTIME);
    wire hit_in = (i_od_index == OD_IDX_IN_MAP);
    wire hit_out = (i_od_index == OD_IDX_OUT_MAP);
    wire sub_zero = (i_od_subidx == OD_SUB_COUNT);
    wire sub_entry = ~sub_zero & (i_od_subidx <= MAP_HIGHEST_SUB);
    wire [7:0] sub_minus = i_od_subidx - 8'h01;
    wire [3:0] rd_slot = sub_minus[3:0];
    wire [31:0] tab_word = hit_in ? in_map_q[rd_slot] : out_map_q[rd_slot];
    wire od_known = (hit_up & sub_zero)
        | ((hit_in | hit_out) & (sub_zero | sub_entry)); // see RULE5
    wire [31:0] od_data = hit_up ? uptime
        : sub_zero ? {24'h00_0000, MAP_HIGHEST_SUB} // see RULE5
        : tab_word;
    wire od_access = i_od_rd | i_od_wr;
    // Every object here is read-only, so any write aborts
    wire od_fail = i_od_wr | ~od_known; // see RULE9
    wire od_good = od_access & ~od_fail;
    logic od_valid_q, od_abort_q;
    logic [31:0] od_rdata_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            od_valid_q <= 1'b0;
            od_abort_q <= 1'b0;
            od_rdata_q <= 32'h0000_0000;
        end
        else
        begin
            od_valid_q <= od_access;
            od_abort_q <= od_access & od_fail;
            od_rdata_q <= od_good ? od_data : 32'h0000_0000;
        end
    end

    assign o_od_valid = od_valid_q;
    assign o_od_abort = od_abort_q;
    assign o_od_rdata = od_rdata_q;

    // =========================================================
    // Copy sequencer
    upm_copy_e state_q, state_d;
    logic [3:0] slot_q, slot_d;
    logic to_img_q, to_img_d;
    logic req_q, req_d;
    logic done_q, done_d;
    logic busy_d;
    logic [31:0] entry_q, entry_d;

    wire [31:0] cur_entry = to_img_q ? in_map_q[slot_q] : out_map_q[slot_q];
    wire cur_used = (cur_entry != MAP_RESET); // see RULE11
    wire last_slot = (slot_q == MAP_LAST_SLOT);
    always_comb
    begin
        state_d = state_q;
        slot_d = slot_q;
        to_img_d = to_img_q;
        req_d = req_q;
        done_d = 1'b0;
        busy_d = busy_q;
        entry_d = entry_q;
        unique case (state_q)
            COPY_IDLE:
            begin
                // Pre-run walk wins if both starts coincide
                if (i_pre_run_start | i_post_run_start)
                begin
                    state_d = COPY_SCAN;
                    slot_d = 4'h0;
                    to_img_d = i_pre_run_start; // see RULE3
                    busy_d = 1'b1;
                end
            end
            COPY_SCAN:
            begin
                if (cur_used)
                begin
                    state_d = COPY_WAIT;
                    req_d = 1'b1;
                    entry_d = cur_entry;
                end
                else if (last_slot)
                begin
                    state_d = COPY_IDLE;
                    done_d = 1'b1;
                    busy_d = 1'b0;
                end
                else
                    slot_d = slot_q + 4'h1; // see RULE11
            end
            COPY_WAIT:
            begin
                if (i_copy_ack)
                begin
                    req_d = 1'b0;
                    if (last_slot)
                    begin
                        state_d = COPY_IDLE;
                        done_d = 1'b1;
                        busy_d = 1'b0;
                    end
                    else
                    begin
                        state_d = COPY_SCAN;
                        slot_d = slot_q + 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            state_q <= COPY_IDLE;
            slot_q <= 4'h0;
            to_img_q <= 1'b0;
            req_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            entry_q <= MAP_RESET;
        end
        else
        begin
            state_q <= state_d;
            slot_q <= slot_d;
            to_img_q <= to_img_d;
            req_q <= req_d;
            done_q <= done_d;
            busy_q <= busy_d;
            entry_q <= entry_d;
        end
    end

    assign o_busy = busy_q;
    assign o_phase_done = done_q;
    assign o_copy_req = req_q;
    // Input walk fills the image; output walk drains it
    assign o_copy_to_image = to_img_q; // see RULE4
    assign o_copy_index = entry_q[MAP_IDX_MSB:MAP_IDX_LSB]; // see RULE8
    assign o_copy_subidx = entry_q[MAP_SUB_MSB:MAP_SUB_LSB]; // see RULE6
    // Length passed through unscaled: units are bits
    assign o_copy_len_bits = entry_q[MAP_LEN_MSB:MAP_LEN_LSB]; // see RULE7
    assign o_copy_slot = slot_q;

    // =========================================================
    // Checks
    property p_sub_count;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_od_rd & ~i_od_wr & (hit_in | hit_out) & sub_zero)
        |=> (o_od_valid & ~o_od_abort & (o_od_rdata == 32'h0000_0010));
    endproperty
    a_sub_count: assert property (p_sub_count) // see RULE5
        else $error("subindex zero did not read 10h");

    property p_write_refused;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_od_wr |=> (o_od_valid & o_od_abort);
    endproperty
    a_write_refused: assert property (p_write_refused) // see RULE9
        else $error("write to read-only object accepted");

    property p_entry_read;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_od_rd & ~i_od_wr & hit_in & sub_entry)
        |=> (o_od_rdata == $past(tab_word));
    endproperty
    a_entry_read: assert property (p_entry_read) // see RULE5
        else $error("map entry read mismatch");

    property p_uptime_read;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_od_rd & ~i_od_wr & hit_up & sub_zero)
        |=> (o_od_rdata == $past(uptime));
    endproperty
    a_uptime_read: assert property (p_uptime_read) // see RULE1
        else $error("uptime read mismatch");

    property p_no_empty_copy;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_copy_req |-> ({o_copy_index, o_copy_subidx, o_copy_len_bits}
            != 32'h0000_0000);
    endproperty
    a_no_empty_copy: assert property (p_no_empty_copy) // see RULE11
        else $error("copy issued for unused entry");

    property p_layout;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(o_copy_req) |-> ({o_copy_index, o_copy_subidx,
            o_copy_len_bits} == (o_copy_to_image ? in_map_q[o_copy_slot]
            : out_map_q[o_copy_slot]));
    endproperty
    a_layout: assert property (p_layout) // see RULE6
        else $error("copy fields do not match entry");

    property p_pre_dir;
        @(posedge i_sys_clk) disable iff (i_rst)
        (~busy_q & i_pre_run_start) |=> (o_busy & o_copy_to_image);
    endproperty
    a_pre_dir: assert property (p_pre_dir) // see RULE3
        else $error("pre-run walk not aimed at image");

    property p_post_dir;
        @(posedge i_sys_clk) disable iff (i_rst)
        (~busy_q & i_post_run_start & ~i_pre_run_start)
        |=> (o_busy & ~o_copy_to_image);
    endproperty
    a_post_dir: assert property (p_post_dir) // see RULE4
        else $error("post-run walk not aimed at objects");

    property p_empty_walk;
        @(posedge i_sys_clk) disable iff (i_rst)
        (busy_q & (state_q == COPY_SCAN) & ~cur_used & last_slot)
        |=> (o_phase_done & ~o_busy);
    endproperty
    a_empty_walk: assert property (p_empty_walk) // see RULE11
        else $error("walk did not end after last slot");

endmodule

// file: sim/upm_copy_partner.sv
// Object dictionary and image side of the copy handshake
`timescale 1ns/1ps
module upm_copy_partner
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_copy_req,
    input wire logic i_copy_to_image,
    input wire logic [15:0] i_copy_index,
    input wire logic [7:0] i_copy_subidx,
    input wire logic [7:0] i_copy_len_bits,
    input wire logic [3:0] i_delay,
    output logic o_copy_ack,
    output logic [31:0] o_last,
    output logic o_last_dir,
    output logic [7:0] o_count
);
    // =========================================================
    // Acknowledge after i_delay cycles, log what was copied
    logic [3:0] wait_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_copy_ack <= 1'b0;
            wait_q <= 4'h0;
            o_last <= 32'h0;
            o_last_dir <= 1'b0;
            o_count <= 8'h00;
        end
        else if (o_copy_ack)
        begin
            // Pulse only, so a held request is not acked twice
            o_copy_ack <= 1'b0;
        end
        else if (i_copy_req && wait_q == i_delay)
        begin
            o_copy_ack <= 1'b1;
            wait_q <= 4'h0;
            o_last <= {i_copy_index, i_copy_subidx, i_copy_len_bits};
            o_last_dir <= i_copy_to_image;
            o_count <= o_count + 8'h01;
        end
        else if (i_copy_req)
        begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// file: sim/upm_uptime_and_map_bench.sv
// Self-checking bench for the uptime object and map tables
`timescale 1ns/1ps
module upm_uptime_and_map_bench;
    import upm_pkg::*;
    localparam int SEC = 8;
    logic clk, rst, rd, wr, ml, mo, ps, qs, ack;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [3:0] ms, dly, cslot;
    logic [31:0] md, rdat, upt, last, v;
    logic vld, abt, busy, done, req, toi, ldir;
    logic [15:0] ci;
    logic [7:0] cs, cl, ncopy;
    int err_total = 0;
    int n_checks = 0;
    int c, k;

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    upm_uptime_and_map #(.P_SECOND_CYCLES(SEC)) i_dut (
        .i_sys_clk(clk), .i_rst(rst), .i_od_rd(rd), .i_od_wr(wr),
        .i_od_index(idx), .i_od_subidx(sub), .o_od_valid(vld),
        .o_od_abort(abt), .o_od_rdata(rdat), .i_map_load(ml),
        .i_map_load_out(mo), .i_map_load_slot(ms), .i_map_load_data(md),
        .i_pre_run_start(ps), .i_post_run_start(qs), .o_busy(busy),
        .o_phase_done(done), .o_copy_req(req), .i_copy_ack(ack),
        .o_copy_to_image(toi), .o_copy_index(ci), .o_copy_subidx(cs),
        .o_copy_len_bits(cl), .o_copy_slot(cslot), .o_uptime_sec(upt));

    upm_copy_partner i_far (
        .i_sys_clk(clk), .i_rst(rst), .i_copy_req(req),
        .i_copy_to_image(toi), .i_copy_index(ci), .i_copy_subidx(cs),
        .i_copy_len_bits(cl), .i_delay(dly), .o_copy_ack(ack),
        .o_last(last), .o_last_dir(ldir), .o_count(ncopy));

    // =========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One access; answer is due exactly one cycle later
    task automatic od(input logic w, input logic [15:0] i,
                      input logic [7:0] s, input logic ab,
                      input logic [31:0] d);
        @(negedge clk);
        rd = ~w;
        wr = w;
        idx = i;
        sub = s;
        @(negedge clk);
        rd = 1'b0;
        wr = 1'b0;
        chk({31'h0, vld}, 32'h1);
        chk({31'h0, abt}, {31'h0, ab});
        chk(rdat, d);
    endtask

    task automatic load(input logic o, input logic [3:0] s,
                        input logic [31:0] d);
        @(negedge clk);
        ml = 1'b1;
        mo = o;
        ms = s;
        md = d;
        @(negedge clk);
        ml = 1'b0;
    endtask

    // Returns cycles from start edge to the done pulse
    task automatic walk(input logic pre, output int cyc);
        @(negedge clk);
        ps = pre;
        qs = ~pre;
        @(negedge clk);
        ps = 1'b0;
        qs = 1'b0;
        chk({31'h0, busy}, 32'h1);
        cyc = 1;
        while (done !== 1'b1 && cyc < 400)
        begin
            @(negedge clk);
            cyc++;
        end
        if (cyc >= 400)
        begin
            err_total++;
            close_out;
        end
        chk({31'h0, busy}, 32'h0);
    endtask

    // =========================================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        {rd, wr, ml, mo, ps, qs} = 6'h00;
        idx = 16'h0;
        sub = 8'h0;
        ms = 4'h0;
        md = 32'h0;
        dly = 4'h0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        od(1'b0, 16'h230f, 8'h00, 1'b0, 32'h0);
        od(1'b0, 16'h2310, 8'h00, 1'b0, 32'h10);
        od(1'b0, 16'h2320, 8'h00, 1'b0, 32'h10);
        od(1'b0, 16'h2310, 8'h01, 1'b0, 32'h0);
        od(1'b0, 16'h2320, 8'h10, 1'b0, 32'h0);
        od(1'b0, 16'h2310, 8'h11, 1'b1, 32'h0);
        od(1'b0, 16'h230f, 8'h01, 1'b1, 32'h0);
        od(1'b0, 16'h2311, 8'h00, 1'b1, 32'h0);
        od(1'b1, 16'h230f, 8'h00, 1'b1, 32'h0);
        // Empty table: sixteen one-cycle skips, no copies
        walk(1'b1, c);
        chk(c, 17);
        chk({24'h0, ncopy}, 32'h0);
        load(1'b0, 4'h0, 32'h6040_0010);
        load(1'b0, 4'hf, 32'h6041_0110);
        load(1'b1, 4'h3, 32'h607a_0020);
        od(1'b1, 16'h2310, 8'h01, 1'b1, 32'h0);
        od(1'b0, 16'h2310, 8'h01, 1'b0, 32'h6040_0010);
        od(1'b0, 16'h2310, 8'h10, 1'b0, 32'h6041_0110);
        od(1'b0, 16'h2320, 8'h04, 1'b0, 32'h607a_0020);
        walk(1'b1, c);
        chk(c, 21);
        chk({24'h0, ncopy}, 32'h2);
        chk({31'h0, ldir}, 32'h1);
        chk(last, 32'h6041_0110);
        // Slow far side, and a load attempt that must be ignored
        dly = 4'h5;
        fork
            walk(1'b0, c);
            begin
                repeat (3) @(negedge clk);
                load(1'b1, 4'h0, 32'h1234_5678);
                // Slot 3 request stands while the slow far side waits
                @(negedge clk);
                chk({31'h0, req}, 32'h1);
                chk({28'h0, cslot}, 32'h3);
                chk({31'h0, toi}, 32'h0);
            end
        join
        chk(c, 24);
        chk({24'h0, ncopy}, 32'h3);
        chk({31'h0, ldir}, 32'h0);
        chk(last, 32'h607a_0020);
        od(1'b0, 16'h2320, 8'h01, 1'b0, 32'h0);
        // One step per prescaler period, not one early or late
        v = upt;
        k = 0;
        while (upt === v && k < 3 * SEC)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 3 * SEC)
        begin
            err_total++;
            close_out;
        end
        v = upt;
        repeat (SEC - 1) @(negedge clk);
        chk(upt, v);
        @(negedge clk);
        chk(upt, v + 32'h1);
        // Reset mid-run clears count and tables
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(upt, 32'h0);
        od(1'b0, 16'h2310, 8'h10, 1'b0, 32'h0);
        close_out;
    end
endmodule
